// ### include/oed_pkg.sv
// Constants and types for the operator entry decoder
package oed_pkg;

   // ********************************************************************
   // Port selection and configuration
   // ********************************************************************
   localparam logic [1:0] OED_AUX_PORT = 2'h2;
   localparam logic OED_ENTRY_ON = 1'h1;

   // ********************************************************************
   // Character codes
   // ********************************************************************
   localparam logic [7:0] OED_CH_BSLASH = 8'h5C;
   localparam logic [7:0] OED_CH_ESC = 8'h1B;
   localparam logic [7:0] OED_CH_ENTER = 8'h0D;
   localparam logic [7:0] OED_CH_MINUS = 8'h2D;
   localparam logic [7:0] OED_CH_PLUS = 8'h2B;
   localparam logic [7:0] OED_CH_POINT = 8'h2E;
   localparam logic [7:0] OED_CH_ZERO = 8'h30;
   localparam logic [7:0] OED_CH_NINE = 8'h39;

   // ********************************************************************
   // Entry status codes (two's complement)
   // ********************************************************************
   localparam logic [2:0] OED_ST_DISABLED = 3'h7;
   localparam logic [2:0] OED_ST_NOTHING = 3'h0;
   localparam logic [2:0] OED_ST_CHARS = 3'h1;
   localparam logic [2:0] OED_ST_STRING = 3'h2;
   localparam logic [2:0] OED_ST_NUMBER = 3'h3;

   // ********************************************************************
   // Communication interrupt settings (two's complement)
   // ********************************************************************
   localparam logic [2:0] OED_CI_OFF = 3'h0;
   localparam logic [2:0] OED_CI_ENTER = 3'h1;
   localparam logic [2:0] OED_CI_ANY = 3'h2;
   localparam logic [2:0] OED_CI_FLUSH = 3'h7;

   // ********************************************************************
   // Variable layout
   // ********************************************************************
   localparam int OED_VAR_BYTES = 6;
   localparam int OED_INT_BYTES = 4;
   localparam int OED_FRAC_BITS = 16;
   localparam logic [2:0] OED_TEXT_MAX = 3'h6;
   localparam logic [2:0] OED_FRAC_DIG_MAX = 3'h4;
   localparam logic [47:0] OED_VAR_RESET = 48'h0000_0000_0000;

   // ********************************************************************
   // Prompt-input sequencer
   // ********************************************************************
   typedef enum logic [1:0] {
      OED_PR_IDLE = 2'b00,
      OED_PR_WAIT = 2'b01,
      OED_PR_DONE = 2'b10
   } oed_prompt_type;

endpackage : oed_pkg

// ### testbench/oed_decoder_asserts.sv
// Concurrent checks on the operator entry decoder ports
`timescale 1ns/1ps
module oed_decoder_asserts (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Inputs watched
   input wire logic cfg_wr_i,
   input wire logic [1:0] cfg_port_i,
   input wire logic cfg_entry_field_i,
   input wire logic prog_running_i,
   input wire logic thread0_running_i,
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_char_i,
   input wire logic ci_wr_i,
   input wire logic [2:0] ci_value_i,
   input wire logic irq_enter_i,
   input wire logic irq_return_i,
   input wire logic irq_reenable_i,
   input wire logic read_text_i,
   // Outputs watched
   input wire logic entry_mode_o,
   input wire logic cfg_refused_o,
   input wire logic [7:0] last_char_value_o,
   input wire logic [2:0] entry_status_code_o,
   input wire logic irq_o,
   input wire logic irq_armed_o,
   input wire logic prompt_stall_o,
   input wire logic prompt_done_o
);
   import oed_pkg::*;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   // ********************************************************************
   // Helpers
   // ********************************************************************
   wire logic quit_ch = rx_char_i == OED_CH_BSLASH || rx_char_i == OED_CH_ESC;
   wire logic plain_ch = !quit_ch && rx_char_i != OED_CH_ENTER;
   // Mode output lags one cycle, so it qualifies the taking edge afterwards
   wire logic taken = rx_valid_i && prog_running_i;

   // ********************************************************************
   // Checks
   // ********************************************************************
   refuse_port_a: assert property (
      cfg_wr_i && cfg_entry_field_i && cfg_port_i != OED_AUX_PORT
      |=> cfg_refused_o) else $error("No refusal for foreign port");
   quit_mode_a: assert property (
      (taken && quit_ch && !cfg_wr_i) ##1 entry_mode_o
      |-> entry_status_code_o == OED_ST_DISABLED ##1 !entry_mode_o)
      else $error("Quit character did not leave mode");
   last_char_a: assert property (
      taken ##1 entry_mode_o |-> last_char_value_o == $past(rx_char_i))
      else $error("Last character not updated");
   chars_status_a: assert property (
      (taken && plain_ch && !cfg_wr_i) ##1 entry_mode_o
      |-> entry_status_code_o == OED_ST_CHARS)
      else $error("Status not one after plain character");
   read_clear_a: assert property (
      read_text_i && entry_status_code_o == OED_ST_STRING && !rx_valid_i
      && !cfg_wr_i && !ci_wr_i |=> entry_status_code_o == OED_ST_NOTHING)
      else $error("Status not cleared by read");
   flush_zero_a: assert property (
      ci_wr_i && ci_value_i == OED_CI_FLUSH && !rx_valid_i && !cfg_wr_i
      && entry_status_code_o != OED_ST_DISABLED
      |=> entry_status_code_o == OED_ST_NOTHING)
      else $error("Flush did not clear status");
   irq_off_a: assert property (
      ci_wr_i && ci_value_i == OED_CI_OFF && !irq_return_i
      |=> !irq_armed_o ##1 !irq_o) else $error("Interrupt still armed");
   enter_disarm_a: assert property (
      irq_enter_i && !irq_return_i && !ci_wr_i |=> !irq_o && !irq_armed_o)
      else $error("Handler entry did not disarm");
   rearm_a: assert property (
      irq_return_i && irq_reenable_i && !ci_wr_i && !irq_enter_i
      |=> irq_armed_o) else $error("Return did not rearm");
   irq_gate_a: assert property (
      irq_o |-> $past(thread0_running_i) && $past(irq_armed_o))
      else $error("Interrupt outside thread zero or unarmed");
   prompt_done_a: assert property (
      prompt_done_o |-> $past(prompt_stall_o))
      else $error("Prompt done without stall");
endmodule : oed_decoder_asserts

bind oed_decoder oed_decoder_asserts chk (
   .mclk_i, .rst_n_i, .cfg_wr_i, .cfg_port_i, .cfg_entry_field_i,
   .prog_running_i, .thread0_running_i, .rx_valid_i, .rx_char_i,
   .ci_wr_i, .ci_value_i, .irq_enter_i, .irq_return_i, .irq_reenable_i,
   .read_text_i, .entry_mode_o, .cfg_refused_o, .last_char_value_o,
   .entry_status_code_o, .irq_o, .irq_armed_o, .prompt_stall_o,
   .prompt_done_o
);

// ### testbench/oed_decoder_bench.sv
// Self-checking bench for the operator entry decoder
`timescale 1ns/1ps
`define CHK(got, exp) begin \
   cmp_count++; \
   if ((got) !== (exp)) begin \
      bad_count++; \
      $display("Error at %0t: got %h expected %h", $time, got, exp); \
   end \
end
module oed_decoder_bench;
   import oed_pkg::*;
   typedef struct {string s; logic [2:0] st; logic [47:0] v;} oed_row_type;

   // ********************************************************************
   // Signals
   // ********************************************************************
   logic mclk_i = 1'b0, rst_n_i = 1'b0, cfg_wr_i = 1'b0;
   logic [1:0] cfg_port_i = 2'h0;
   logic cfg_entry_field_i = 1'b0, prog_running_i = 1'b1;
   logic thread0_running_i = 1'b1, rx_valid_i, ci_wr_i = 1'b0;
   logic [7:0] rx_char_i;
   logic [2:0] ci_value_i = 3'h0, prompt_len_i = 3'h0;
   logic irq_enter_i = 1'b0, irq_return_i = 1'b0, irq_reenable_i = 1'b0;
   logic read_text_i = 1'b0, read_num_i = 1'b0;
   logic prompt_req_i = 1'b0, prompt_text_i = 1'b0;
   logic entry_mode_o, cfg_refused_o, irq_o, irq_armed_o;
   logic prompt_stall_o, prompt_done_o;
   logic [7:0] last_char_value_o;
   logic [47:0] received_text_value_o, received_numeric_value_o;
   logic [47:0] prompt_data_o;
   logic [2:0] entry_status_code_o;
   int bad_count = 0;
   int cmp_count = 0;
   // Ordinary entries and what the decoder must make of them
   oed_row_type rows [8] = '{
      '{"12", OED_ST_NUMBER, 48'h0000_000C_0000},
      '{"-5", OED_ST_NUMBER, 48'hFFFF_FFFB_0000},
      '{"+7", OED_ST_NUMBER, 48'h0000_0007_0000},
      '{"1.5", OED_ST_NUMBER, 48'h0000_0001_8000},
      '{"1.23456", OED_ST_NUMBER, 48'h0000_0001_3C08},
      '{"ABC", OED_ST_STRING, 48'h4142_4300_0000},
      '{"ABCDEFGH", OED_ST_STRING, 48'h4142_4344_4546},
      '{"1a", OED_ST_STRING, 48'h3161_0000_0000}};

   always #2 mclk_i = ~mclk_i;

   oed_decoder uut (.mclk_i, .rst_n_i, .cfg_wr_i, .cfg_port_i,
      .cfg_entry_field_i, .prog_running_i, .thread0_running_i, .rx_valid_i,
      .rx_char_i, .ci_wr_i, .ci_value_i, .irq_enter_i, .irq_return_i,
      .irq_reenable_i, .read_text_i, .read_num_i, .prompt_req_i,
      .prompt_text_i, .prompt_len_i, .entry_mode_o, .cfg_refused_o,
      .last_char_value_o, .received_text_value_o, .received_numeric_value_o,
      .entry_status_code_o, .irq_o, .irq_armed_o, .prompt_stall_o,
      .prompt_done_o, .prompt_data_o);
   oed_terminal term (.mclk_i, .rx_valid_o(rx_valid_i),
      .rx_char_o(rx_char_i));

   // ********************************************************************
   // Tasks
   // ********************************************************************
   task automatic tick(input int n);
      repeat (n) @(negedge mclk_i);
   endtask : tick
   task automatic pulse(ref logic sig);
      @(negedge mclk_i);
      sig = 1'b1;
      @(negedge mclk_i);
      sig = 1'b0;
   endtask : pulse
   // Bounded so a missing pulse cannot hang the run
   task automatic wait_hi(ref logic sig, input int lim);
      int n;
      n = 0;
      while (sig !== 1'b1 && n < lim) begin
         @(negedge mclk_i);
         n++;
      end
   endtask : wait_hi
   task automatic entry(input string s);
      foreach (s[i]) term.send(s[i]);
      term.send(OED_CH_ENTER);
   endtask : entry
   task automatic done_test(input string name);
      $display("Test %s finished", name);
   endtask : done_test
   task automatic set_ci(input logic [2:0] v);
      ci_value_i = v;
      pulse(ci_wr_i);
      tick(1);
   endtask : set_ci
   task automatic prompt_case(input logic txt, input logic [2:0] len,
                              input string s, input logic [47:0] exp);
      set_ci(OED_CI_FLUSH);
      prompt_text_i = txt;
      prompt_len_i = len;
      pulse(prompt_req_i);
      tick(1);
      `CHK(prompt_stall_o, 1'b1)
      entry(s);
      wait_hi(prompt_done_o, 3);
      `CHK(prompt_done_o, 1'b1)
      `CHK(prompt_data_o, exp)
      tick(1);
      `CHK(prompt_stall_o, 1'b0)
   endtask : prompt_case
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report

   // ********************************************************************
   // Sequence
   // ********************************************************************
   initial begin
      tick(10);
      rst_n_i = 1'b1;
      `CHK(entry_status_code_o, OED_ST_DISABLED)
      `CHK(entry_mode_o, 1'b0)
      done_test("reset");
      cfg_port_i = 2'h1;
      cfg_entry_field_i = OED_ENTRY_ON;
      pulse(cfg_wr_i);
      wait_hi(cfg_refused_o, 3);
      `CHK(cfg_refused_o, 1'b1)
      tick(2);
      `CHK(entry_mode_o, 1'b0)
      cfg_port_i = OED_AUX_PORT;
      pulse(cfg_wr_i);
      tick(1);
      `CHK(entry_mode_o, 1'b1)
      `CHK(entry_status_code_o, OED_ST_NOTHING)
      done_test("config");
      foreach (rows[i]) begin
         entry(rows[i].s);
         `CHK(entry_status_code_o, rows[i].st)
         if (rows[i].st == OED_ST_NUMBER) begin
            `CHK(received_numeric_value_o, rows[i].v)
            pulse(read_num_i);
         end else begin
            `CHK(received_text_value_o, rows[i].v)
            pulse(read_text_i);
         end
         `CHK(entry_status_code_o, OED_ST_NOTHING)
      end
      done_test("rows");
      term.send("Q");
      `CHK(last_char_value_o, 8'h51)
      `CHK(entry_status_code_o, OED_ST_CHARS)
      prog_running_i = 1'b0;
      term.send("R");
      `CHK(last_char_value_o, 8'h51)
      prog_running_i = 1'b1;
      term.send("B");
      set_ci(OED_CI_FLUSH);
      `CHK(entry_status_code_o, OED_ST_NOTHING)
      term.send(OED_CH_ENTER);
      `CHK(entry_status_code_o, OED_ST_STRING)
      `CHK(received_text_value_o, 48'h0000_0000_0000)
      done_test("flush");
      set_ci(OED_CI_ENTER);
      `CHK(irq_armed_o, 1'b1)
      term.send("x");
      tick(1);
      `CHK(irq_o, 1'b0)
      term.send(OED_CH_ENTER);
      tick(1);
      `CHK(irq_o, 1'b1)
      pulse(irq_enter_i);
      tick(1);
      `CHK(irq_o, 1'b0)
      `CHK(irq_armed_o, 1'b0)
      irq_reenable_i = 1'b1;
      pulse(irq_return_i);
      tick(1);
      `CHK(irq_armed_o, 1'b1)
      set_ci(OED_CI_ANY);
      term.send("y");
      tick(1);
      `CHK(irq_o, 1'b1)
      thread0_running_i = 1'b0;
      tick(2);
      `CHK(irq_o, 1'b0)
      thread0_running_i = 1'b1;
      tick(2);
      `CHK(irq_o, 1'b1)
      set_ci(OED_CI_OFF);
      tick(1);
      `CHK(irq_armed_o, 1'b0)
      `CHK(irq_o, 1'b0)
      done_test("interrupt");
      prompt_case(1'b1, 3'h3, "ABCDE", 48'h4142_4300_0000);
      prompt_case(1'b1, 3'h0, "ABCDEFG", 48'h4142_4344_4546);
      prompt_case(1'b0, 3'h0, "-5", 48'hFFFF_FFFB_0000);
      done_test("prompt");
      foreach (rows[i]) begin
         if (i < 2) begin
            pulse(cfg_wr_i);
            tick(1);
            term.send(i == 0 ? OED_CH_BSLASH : OED_CH_ESC);
            `CHK(entry_status_code_o, OED_ST_DISABLED)
            tick(1);
            `CHK(entry_mode_o, 1'b0)
         end
      end
      term.send("Z");
      `CHK(last_char_value_o, OED_CH_ESC)
      done_test("exit");
      final_report();
   end

   // Generous against the few hundred cycles the sequence needs
   initial begin
      #100000;
      bad_count++;
      final_report();
   end
endmodule : oed_decoder_bench

// ### testbench/oed_terminal.sv
// Operator terminal model feeding characters to the decoder
`timescale 1ns/1ps
module oed_terminal (
   // Clock
   input wire logic mclk_i,
   // Character stream toward the decoder
   output logic rx_valid_o,
   output logic [7:0] rx_char_o
);
   initial begin
      rx_valid_o = 1'b0;
      rx_char_o = 8'h00;
   end

   // ********************************************************************
   // One character per call, launched on the falling edge
   // ********************************************************************
   task automatic send(input logic [7:0] ch);
      @(negedge mclk_i);
      rx_valid_o = 1'b1;
      rx_char_o = ch;
      @(negedge mclk_i);
      rx_valid_o = 1'b0;
      // Inverse when idle, so stale data never passes for fresh
      rx_char_o = ~ch;
   endtask : send
endmodule : oed_terminal

// ### verilog/oed_decoder.sv
// Operator entry decoder for the auxiliary serial port
`timescale 1ns/1ps

// How it works
// - Entry mode accepted only for port 2
// - Backslash or escape leaves entry mode
// - Receive buffer collects incoming auxiliary characters
// - Last character held, updated every character taken in entry mode while the program runs
// - Complete received string held readable
// - Numeric entry value held readable
// - Status code -1,0,1,2,3 reported
// - Reading string or number zeroes status
// - Interrupt setting: none, enter, any character
// - Setting -1 discards pending buffered characters
// - Handler entry disarms; return may rearm
// - Interrupt serviced only while thread 0 runs
// - Prompt input stalls until data arrives
// - Text input up to six, default six
// - Variables six bytes: 4 integer, 2 fraction
// - First character lands in top byte
module oed_decoder (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // Port configuration command
   input wire logic cfg_wr_i,
   input wire logic [1:0] cfg_port_i,
   input wire logic cfg_entry_field_i,
   // Program state
   input wire logic prog_running_i,
   input wire logic thread0_running_i,
   // Received characters
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_char_i,
   // Communication interrupt setting and handler
   input wire logic ci_wr_i,
   input wire logic [2:0] ci_value_i,
   input wire logic irq_enter_i,
   input wire logic irq_return_i,
   input wire logic irq_reenable_i,
   // Value reads
   input wire logic read_text_i,
   input wire logic read_num_i,
   // Prompt input command
   input wire logic prompt_req_i,
   input wire logic prompt_text_i,
   input wire logic [2:0] prompt_len_i,
   // Mode and configuration status
   output logic entry_mode_o,
   output logic cfg_refused_o,
   // Decoded values
   output logic [7:0] last_char_value_o,
   output logic [47:0] received_text_value_o,
   output logic [47:0] received_numeric_value_o,
   output logic [2:0] entry_status_code_o,
   // Interrupt
   output logic irq_o,
   output logic irq_armed_o,
   // Prompt input results
   output logic prompt_stall_o,
   output logic prompt_done_o,
   output logic [47:0] prompt_data_o
);
   import oed_pkg::*;

   // ********************************************************************
   // Helper functions
   // ********************************************************************
   function automatic logic is_digit(input logic [7:0] c);
      is_digit = (c >= OED_CH_ZERO) && (c <= OED_CH_NINE);
   endfunction : is_digit

   // Decimal fraction digits to binary 16-bit fraction
   function automatic logic [15:0] frac_conv(input logic [13:0] f,
                                             input logic [2:0] k);
      logic [29:0] p;
      p = {f, 16'h0000};
      case (k)
         3'h1: frac_conv = 16'(p / 30'd10);
         3'h2: frac_conv = 16'(p / 30'd100);
         3'h3: frac_conv = 16'(p / 30'd1000);
         3'h4: frac_conv = 16'(p / 30'd10000);
         default: frac_conv = 16'h0000;
      endcase
   endfunction : frac_conv

   // Pack up to lim characters, first into the top byte
   function automatic logic [47:0] pack_text(input logic [47:0] flat,
                                             input logic [2:0] n,
                                             input logic [2:0] lim);
      logic [47:0] r;
      logic [2:0] use_n;
      r = OED_VAR_RESET;
      use_n = (n < lim) ? n : lim;
      for (int i = 0; i < OED_VAR_BYTES; i++) begin
         if (3'(i) < use_n) begin
            r[47 - 8*i -: 8] = flat[47 - 8*i -: 8];
         end
      end
      pack_text = r;
   endfunction : pack_text

   // ********************************************************************
   // Character classification
   // ********************************************************************
   logic mode_on;
   logic rx_take;
   logic is_exit;
   logic is_enter;
   logic is_plain;
   logic flush;

   assign flush = ci_wr_i && (ci_value_i == OED_CI_FLUSH);
   assign rx_take = rx_valid_i && mode_on && prog_running_i;
   assign is_exit = rx_take && ((rx_char_i == OED_CH_BSLASH) ||
                                (rx_char_i == OED_CH_ESC));
   assign is_enter = rx_take && (rx_char_i == OED_CH_ENTER);
   assign is_plain = rx_take && !is_exit && !is_enter;

   // ********************************************************************
   // Mode control
   // ********************************************************************
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         mode_on <= 1'b0;
         cfg_refused_o <= 1'b0;
      end else begin
         cfg_refused_o <= 1'b0;
         if (cfg_wr_i) begin
            if (cfg_port_i == OED_AUX_PORT) begin
               mode_on <= (cfg_entry_field_i == OED_ENTRY_ON);
            end else if (cfg_entry_field_i == OED_ENTRY_ON) begin
               cfg_refused_o <= 1'b1;
            end
         end else if (is_exit) begin
            mode_on <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         entry_mode_o <= 1'b0;
      end else begin
         entry_mode_o <= mode_on;
      end
   end

   // ********************************************************************
   // Receive buffer
   // ********************************************************************
   logic [7:0] buf_mem [0:OED_VAR_BYTES-1];
   logic [2:0] buf_cnt;
   logic [47:0] buf_flat;

   always_comb begin
      buf_flat = OED_VAR_RESET;
      for (int i = 0; i < OED_VAR_BYTES; i++) begin
         buf_flat[47 - 8*i -: 8] = buf_mem[i];
      end
   end

   // Extra characters past six are dropped; a variable holds no more
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         buf_cnt <= 3'h0;
         for (int i = 0; i < OED_VAR_BYTES; i++) begin
            buf_mem[i] <= 8'h00;
         end
      end else if (flush || is_enter || is_exit) begin
         buf_cnt <= 3'h0;
      end else if (is_plain && (buf_cnt < OED_TEXT_MAX)) begin
         buf_mem[buf_cnt] <= rx_char_i;
         buf_cnt <= 3'(buf_cnt + 3'h1);
      end
   end

   // ********************************************************************
   // Number parser, runs as characters arrive
   // ********************************************************************
   logic num_ok;
   logic seen_digit;
   logic seen_point;
   logic neg;
   logic any_char;
   logic [31:0] int_acc;
   logic [13:0] frac_acc;
   logic [2:0] frac_dig;
   logic [3:0] dval;

   assign dval = 4'(rx_char_i - OED_CH_ZERO);

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i || flush || is_enter || is_exit) begin
         num_ok <= 1'b1;
         seen_digit <= 1'b0;
         seen_point <= 1'b0;
         neg <= 1'b0;
         any_char <= 1'b0;
         int_acc <= 32'h0000_0000;
         frac_acc <= 14'h0000;
         frac_dig <= 3'h0;
      end else if (is_plain) begin
         any_char <= 1'b1;
         if (!any_char && (rx_char_i == OED_CH_MINUS)) begin
            neg <= 1'b1;
         end else if (!any_char && (rx_char_i == OED_CH_PLUS)) begin
            neg <= 1'b0;
         end else if (is_digit(rx_char_i)) begin
            seen_digit <= 1'b1;
            if (!seen_point) begin
               int_acc <= 32'(int_acc * 32'd10 + {28'h000_0000, dval});
            end else if (frac_dig < OED_FRAC_DIG_MAX) begin
               frac_acc <= 14'(frac_acc * 14'd10 + {10'h000, dval});
               frac_dig <= 3'(frac_dig + 3'h1);
            end
         end else if ((rx_char_i == OED_CH_POINT) && !seen_point) begin
            seen_point <= 1'b1;
         end else begin
            num_ok <= 1'b0;
         end
      end
   end

   logic is_number;
   logic [47:0] num_mag;
   logic [47:0] num_val;

   assign is_number = num_ok && seen_digit;
   assign num_mag = {int_acc, frac_conv(frac_acc, frac_dig)};
   assign num_val = neg ? 48'(~num_mag + 48'h0000_0000_0001) : num_mag;

   // ********************************************************************
   // Decoded values
   // ********************************************************************
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         last_char_value_o <= 8'h00;
      end else if (rx_take) begin
         last_char_value_o <= rx_char_i;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         received_text_value_o <= OED_VAR_RESET;
         received_numeric_value_o <= OED_VAR_RESET;
      end else if (is_enter) begin
         if (is_number) begin
            received_numeric_value_o <= num_val;
         end else begin
            received_text_value_o <=
               pack_text(buf_flat, buf_cnt, OED_TEXT_MAX);
         end
      end
   end

   // ********************************************************************
   // Entry status code
   // ********************************************************************
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         entry_status_code_o <= OED_ST_DISABLED;
      end else if (!mode_on || is_exit) begin
         entry_status_code_o <= OED_ST_DISABLED;
      end else if (is_enter) begin
         entry_status_code_o <= is_number ? OED_ST_NUMBER
                                          : OED_ST_STRING;
      end else if (is_plain) begin
         entry_status_code_o <= OED_ST_CHARS;
      end else if (flush ||
                   (entry_status_code_o == OED_ST_DISABLED)) begin
         entry_status_code_o <= OED_ST_NOTHING;
      end else if ((read_text_i &&
                    (entry_status_code_o == OED_ST_STRING)) ||
                   (read_num_i &&
                    (entry_status_code_o == OED_ST_NUMBER))) begin
         entry_status_code_o <= OED_ST_NOTHING;
      end
   end

   // ********************************************************************
   // Communication interrupt
   // ********************************************************************
   logic [2:0] ci_mode;
   logic irq_pend;
   logic irq_event;

   assign irq_event = ((ci_mode == OED_CI_ANY) && is_plain) ||
                      (((ci_mode == OED_CI_ANY) ||
                        (ci_mode == OED_CI_ENTER)) && is_enter);

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ci_mode <= OED_CI_OFF;
      end else if (ci_wr_i && (ci_value_i != OED_CI_FLUSH)) begin
         ci_mode <= ci_value_i;
      end
   end

   // Arming follows a setting write unless handler entry or a rearming return comes in the same cycle; flush keeps the arm state
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         irq_armed_o <= 1'b0;
      end else if (irq_enter_i) begin
         irq_armed_o <= 1'b0;
      end else if (irq_return_i && irq_reenable_i) begin
         irq_armed_o <= 1'b1;
      end else if (ci_wr_i && (ci_value_i != OED_CI_FLUSH)) begin
         irq_armed_o <= (ci_value_i != OED_CI_OFF);
      end
   end

   // A new event in the handler-entry cycle stays pending
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         irq_pend <= 1'b0;
      end else if (irq_event) begin
         irq_pend <= 1'b1;
      end else if (irq_enter_i || flush) begin
         irq_pend <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= irq_pend && irq_armed_o && !irq_enter_i &&
                  thread0_running_i;
      end
   end

   // ********************************************************************
   // Prompt input sequencer
   // ********************************************************************
   oed_prompt_type pr_state;
   oed_prompt_type next_pr_state;
   logic pr_text;
   logic [2:0] pr_len;

   always_comb begin
      next_pr_state = pr_state;
      case (pr_state)
         OED_PR_IDLE: begin
            if (prompt_req_i && mode_on) begin
               next_pr_state = OED_PR_WAIT;
            end
         end
         OED_PR_WAIT: begin
            if (is_enter) begin
               next_pr_state = OED_PR_DONE;
            end else if (is_exit || !mode_on) begin
               next_pr_state = OED_PR_IDLE;
            end
         end
         OED_PR_DONE: next_pr_state = OED_PR_IDLE;
         default: next_pr_state = OED_PR_IDLE;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         pr_state <= OED_PR_IDLE;
      end else begin
         pr_state <= next_pr_state;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         pr_text <= 1'b0;
         pr_len <= OED_TEXT_MAX;
      end else if ((pr_state == OED_PR_IDLE) && prompt_req_i) begin
         pr_text <= prompt_text_i;
         if ((prompt_len_i == 3'h0) || (prompt_len_i > OED_TEXT_MAX)) begin
            pr_len <= OED_TEXT_MAX;
         end else begin
            pr_len <= prompt_len_i;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         prompt_stall_o <= 1'b0;
         prompt_done_o <= 1'b0;
         prompt_data_o <= OED_VAR_RESET;
      end else begin
         prompt_stall_o <= (next_pr_state == OED_PR_WAIT);
         prompt_done_o <= (pr_state == OED_PR_WAIT) && is_enter;
         if ((pr_state == OED_PR_WAIT) && is_enter) begin
            if (pr_text) begin
               prompt_data_o <= pack_text(buf_flat, buf_cnt, pr_len);
            end else begin
               prompt_data_o <= is_number ? num_val : OED_VAR_RESET;
            end
         end
      end
   end

endmodule : oed_decoder
